// >>> logic/eewr_core.sv
// core: serial eeprom command shifter, write and write-all programming engine
// Contract
// - write loads 8 or 16 data bits
// - self-timed erase then program at select fall
// - select high after min low shows status, only while programming runs
// - status low while programming runs
// - status high once ready
// - write-all programs every location with data
// - write-all self-timed, starts at select fall
// - write-all needs no further serial clocks
// - write-all erases whole array first
// - write-all only while programming enabled
// - status available during write-all too
// - start bit: first edge with select and input
// - bits sampled on serial clock rising edge
// - programming disabled at power-up until enable
// - output released at every select fall
`timescale 1ns/1ps
module eewr_core
	import eewr_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int ADDR_W = 6,
	parameter int PROG_CYCLES = EEWR_PROG_CYCLES_DEF
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire eewr_pins_t pins_i,
	output logic serial_out_o,
	output logic serial_out_oe_o,
	output logic busy_o,
	output logic prog_enabled_o
);
	localparam int CMD_W = 2 + ADDR_W + DATA_W;
	localparam int WORDS = 1 << ADDR_W;
	localparam int CNT_W = $clog2(CMD_W + 1);
	localparam int PC_W = $clog2(PROG_CYCLES + 1);
	localparam int LC_W = $clog2(EEWR_SELECT_LOW_MIN_CYC + 1);

	logic [DATA_W-1:0] mem [WORDS];
	eewr_phase_t phase;
	eewr_prog_t prog;
	logic [CMD_W-1:0] shreg;
	logic [CNT_W-1:0] bit_cnt;
	logic sclk_q;
	logic sel_q;
	logic enabled;
	logic pend_write;
	logic pend_all;
	logic all_mode;
	logic [ADDR_W-1:0] tgt_addr;
	logic [DATA_W-1:0] tgt_data;
	logic [ADDR_W-1:0] sweep;
	logic [PC_W-1:0] prog_cnt;
	logic [LC_W-1:0] low_cnt;

	logic sclk_rise;
	logic sel_fall;
	logic sel_rise;
	logic [CMD_W-1:0] next_shreg;
	logic [1:0] op;
	logic [1:0] ext;
	logic [1:0] op_s;
	logic [1:0] ext_s;
	logic [ADDR_W-1:0] addr_f;
	logic [DATA_W-1:0] data_f;
	logic short_cmd;
	logic long_cmd;

	assign sclk_rise = pins_i.sclk && !sclk_q;
	assign sel_fall = sel_q && !pins_i.sel;
	assign sel_rise = !sel_q && pins_i.sel;
	assign next_shreg = {shreg[CMD_W-2:0], pins_i.serial_in};
	// field view of the command as it stands after this clock's bit
	assign op = next_shreg[CMD_W-1 -: 2];
	assign ext = next_shreg[CMD_W-3 -: 2];
	// a short command has only filled the low bits, so its fields sit lower down
	assign op_s = next_shreg[2+ADDR_W-1 -: 2];
	assign ext_s = next_shreg[ADDR_W-1 -: 2];
	assign addr_f = next_shreg[DATA_W +: ADDR_W];
	assign data_f = next_shreg[DATA_W-1:0];
	assign short_cmd = bit_cnt == CNT_W'(2 + ADDR_W - 1);
	assign long_cmd = bit_cnt == CNT_W'(CMD_W - 1);

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_q <= 1'b0;
			sel_q <= 1'b0;
		end else if (ce_i) begin
			sclk_q <= pins_i.sclk;
			sel_q <= pins_i.sel;
		end
	end

	// serial command decoder
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			phase <= EEWR_PH_IDLE;
			shreg <= '0;
			bit_cnt <= '0;
			enabled <= 1'b0;
			pend_write <= 1'b0;
			pend_all <= 1'b0;
			tgt_addr <= '0;
			tgt_data <= '0;
		end else if (ce_i) begin
			if (!pins_i.sel) begin
				phase <= EEWR_PH_IDLE;
				bit_cnt <= '0;
				if (sel_fall) begin
					pend_write <= 1'b0;
					pend_all <= 1'b0;
				end
			end else if (sclk_rise) begin
				unique case (phase)
					EEWR_PH_IDLE: begin
						// a busy part ignores new commands until it is ready
						if (pins_i.serial_in && prog == EEWR_PG_IDLE) begin
							phase <= EEWR_PH_SHIFT;
							bit_cnt <= '0;
							shreg <= '0;
						end
					end
					EEWR_PH_SHIFT: begin
						shreg <= next_shreg;
						bit_cnt <= bit_cnt + CNT_W'(1);
						if (short_cmd && op_s == EEWR_OP_EXT && ext_s != EEWR_EXT_WRITE_ALL) begin
							phase <= EEWR_PH_DONE;
							if (ext_s == EEWR_EXT_ENABLE) begin
								enabled <= 1'b1;
							end else if (ext_s == EEWR_EXT_DISABLE) begin
								enabled <= 1'b0;
							end
						end else if (short_cmd && op_s[1]) begin
							// read and single erase opcodes end the frame here and are not carried out
							phase <= EEWR_PH_DONE;
						end else if (long_cmd) begin
							phase <= EEWR_PH_DONE;
							tgt_addr <= addr_f;
							tgt_data <= data_f;
							pend_write <= enabled && op == EEWR_OP_WRITE;
							pend_all <= enabled && op == EEWR_OP_EXT;
						end
					end
					EEWR_PH_DONE: begin
					end
					default: phase <= EEWR_PH_IDLE;
				endcase
			end
		end
	end

	// self-timed engine, runs off the system clock only
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			prog <= EEWR_PG_IDLE;
			prog_cnt <= '0;
			all_mode <= 1'b0;
			sweep <= '0;
		end else if (ce_i) begin
			unique case (prog)
				EEWR_PG_IDLE: begin
					if (sel_fall && (pend_write || pend_all)) begin
						prog <= EEWR_PG_ERASE;
						all_mode <= pend_all;
						prog_cnt <= '0;
						sweep <= '0;
					end
				end
				EEWR_PG_ERASE: begin
					if (prog_cnt == PC_W'(PROG_CYCLES - 1)) begin
						prog_cnt <= '0;
						sweep <= sweep + ADDR_W'(1);
						if (!all_mode || sweep == ADDR_W'(WORDS - 1)) begin
							prog <= EEWR_PG_PROGRAM;
							sweep <= '0;
						end
					end else begin
						prog_cnt <= prog_cnt + PC_W'(1);
					end
				end
				EEWR_PG_PROGRAM: begin
					if (prog_cnt == PC_W'(PROG_CYCLES - 1)) begin
						prog_cnt <= '0;
						sweep <= sweep + ADDR_W'(1);
						if (!all_mode || sweep == ADDR_W'(WORDS - 1)) begin
							prog <= EEWR_PG_IDLE;
						end
					end else begin
						prog_cnt <= prog_cnt + PC_W'(1);
					end
				end
				default: prog <= EEWR_PG_IDLE;
			endcase
		end
	end

	// array cells: erase sets ones, program stores the captured word
	always_ff @(posedge clk_sys_i) begin
		if (ce_i && prog_cnt == PC_W'(PROG_CYCLES - 1)) begin
			if (prog == EEWR_PG_ERASE) begin
				mem[all_mode ? sweep : tgt_addr] <= '1;
			end else if (prog == EEWR_PG_PROGRAM) begin
				mem[all_mode ? sweep : tgt_addr] <= tgt_data;
			end
		end
	end

	// low time of select counted so status only follows a legal pulse
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			low_cnt <= '0;
		end else if (ce_i) begin
			if (pins_i.sel) begin
				low_cnt <= '0;
			end else if (low_cnt != LC_W'(EEWR_SELECT_LOW_MIN_CYC)) begin
				low_cnt <= low_cnt + LC_W'(1);
			end
		end
	end

	// status pin; busy flag is cleared one cycle after the engine finishes
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			serial_out_o <= 1'b0;
			serial_out_oe_o <= 1'b0;
			busy_o <= 1'b0;
			prog_enabled_o <= 1'b0;
		end else if (ce_i) begin
			busy_o <= prog != EEWR_PG_IDLE || (sel_fall && (pend_write || pend_all));
			prog_enabled_o <= enabled;
			if (sel_fall) begin
				serial_out_oe_o <= 1'b0;
			end else if (sel_rise && low_cnt == LC_W'(EEWR_SELECT_LOW_MIN_CYC)
				&& (prog != EEWR_PG_IDLE)) begin
				serial_out_oe_o <= 1'b1;
			end
			if (serial_out_oe_o || sel_rise) begin
				serial_out_o <= prog == EEWR_PG_IDLE;
			end
		end
	end
endmodule

// >>> common/eewr_pkg.sv
// package: constants and types for the serial eeprom write path
package eewr_pkg;
	localparam int EEWR_SELECT_LOW_MIN_NS = 250;
	localparam int EEWR_CLK_PERIOD_NS = 25;
	localparam int EEWR_SELECT_LOW_MIN_CYC =
		(EEWR_SELECT_LOW_MIN_NS + EEWR_CLK_PERIOD_NS - 1) / EEWR_CLK_PERIOD_NS;
	localparam int EEWR_PROG_CYCLES_DEF = 200;
	localparam logic [1:0] EEWR_OP_EXT = 2'h0;
	localparam logic [1:0] EEWR_OP_WRITE = 2'h1;
	localparam logic [1:0] EEWR_EXT_DISABLE = 2'h0;
	localparam logic [1:0] EEWR_EXT_WRITE_ALL = 2'h1;
	localparam logic [1:0] EEWR_EXT_ERASE_ALL = 2'h2;
	localparam logic [1:0] EEWR_EXT_ENABLE = 2'h3;

	typedef enum logic [1:0] {
		EEWR_PH_IDLE,
		EEWR_PH_SHIFT,
		EEWR_PH_DONE
	} eewr_phase_t;

	typedef enum logic [1:0] {
		EEWR_PG_IDLE,
		EEWR_PG_ERASE,
		EEWR_PG_PROGRAM
	} eewr_prog_t;

	typedef struct packed {
		logic sel;
		logic sclk;
		logic serial_in;
	} eewr_pins_t;
endpackage

// >>> test/eewr_core_sva.sv
// checker: port-level properties of the eeprom write core
`timescale 1ns/1ps
module eewr_core_sva
	import eewr_pkg::*;
#(
	parameter int ADDR_W = 6,
	parameter int PROG_CYCLES = 4
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire eewr_pins_t pins_i,
	input wire logic serial_out_o,
	input wire logic serial_out_oe_o,
	input wire logic busy_o,
	input wire logic prog_enabled_o
);
	logic [31:0] busy_len;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			busy_len <= '0;
		end else if (ce_i) begin
			// frozen cycles do not advance the engine, so they are not counted
			busy_len <= busy_o ? busy_len + 32'h1 : 32'h0;
		end
	end
	// ten samples of select low while busy, then raised
	sequence s_low_raise;
		(busy_o && !pins_i.sel)[*8] ##1 (busy_o && !pins_i.sel)[*2] ##1 (busy_o && pins_i.sel);
	endsequence
	// busy one cycle later means the engine itself was still running at the raise
	a_status_shown: assert property (s_low_raise ##1 busy_o |-> serial_out_oe_o)
		else $error("status not driven after select raised");
	a_oe_cause: assert property ($rose(serial_out_oe_o) |->
		$past(pins_i.sel) && !$past(pins_i.sel, 2) && !$past(pins_i.sel, 11))
		else $error("status driven without a long enough select low");
	a_status_busy_low: assert property (serial_out_oe_o && $past(serial_out_oe_o) && busy_o
		&& $past(busy_o) |-> !serial_out_o)
		else $error("status not low while programming");
	a_status_ready_high: assert property (serial_out_oe_o && $past(serial_out_oe_o) && !busy_o
		&& !$past(busy_o) |-> serial_out_o)
		else $error("status not high when ready");
	a_release_on_fall: assert property ($fell(pins_i.sel) |=> !serial_out_oe_o)
		else $error("data out not released after select fall");
	a_busy_from_fall: assert property ($rose(busy_o) |-> !$past(pins_i.sel)
		&& $past(pins_i.sel, 2))
		else $error("programming began without a select fall");
	a_busy_needs_enable: assert property ($rose(busy_o) |-> prog_enabled_o)
		else $error("programming began while disabled");
	// busy is registered from the engine state, so it stands one cycle past the steps
	a_cycle_length: assert property ($fell(busy_o) |-> busy_len == 32'(2 * PROG_CYCLES + 1)
		|| busy_len == 32'(((2 * PROG_CYCLES) << ADDR_W) + 1))
		else $error("programming cycle length wrong");
	a_enable_stable: assert property ($changed(prog_enabled_o) |-> !busy_o)
		else $error("enable state changed during programming");
endmodule
bind eewr_core eewr_core_sva #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)) eewr_core_sva_inst (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .pins_i(pins_i),
	.serial_out_o(serial_out_o),
	.serial_out_oe_o(serial_out_oe_o), .busy_o(busy_o), .prog_enabled_o(prog_enabled_o));

// >>> test/eewr_host.sv
// host model: shifts command frames into the device
`timescale 1ns/1ps
module eewr_host
	import eewr_pkg::*;
(
	input wire logic clk_sys_i,
	output eewr_pins_t pins_o
);
	initial pins_o = '0;
	// bits msb first; the first one bit is the start bit
	task automatic frame(input logic [31:0] bits, input int n);
		pins_o.sel = 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge clk_sys_i);
			pins_o.serial_in = bits[i];
			pins_o.sclk = 1'b0;
			@(negedge clk_sys_i);
			pins_o.sclk = 1'b1;
		end
		@(negedge clk_sys_i);
		pins_o.sclk = 1'b0;
		@(negedge clk_sys_i);
		pins_o.sel = 1'b0;
		pins_o.serial_in = ~pins_o.serial_in;
	endtask
	task automatic select(input logic v);
		pins_o.sel = v;
	endtask
endmodule

// >>> test/eewr_core_bench.sv
// bench: drives command frames and judges status and busy timing
`timescale 1ns/1ps
module eewr_core_bench
	import eewr_pkg::*;
;
	localparam int PC = 8;
	localparam logic [31:0] WR = {7'h0, 1'h1, EEWR_OP_WRITE, 6'h2a, 16'ha5c3};
	localparam logic [31:0] WA = {7'h0, 1'h1, EEWR_OP_EXT, EEWR_EXT_WRITE_ALL, 4'h0, 16'h5a3c};
	localparam logic [31:0] EN = {21'h0, 2'h0, 1'h1, EEWR_OP_EXT, EEWR_EXT_ENABLE, 4'h0};
	localparam logic [31:0] DIS = {23'h0, 1'h1, EEWR_OP_EXT, EEWR_EXT_DISABLE, 4'h0};
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	eewr_pins_t pins;
	logic serial_out_o, serial_out_oe_o, busy_o, prog_enabled_o;
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	eewr_core #(.PROG_CYCLES(PC)) eewr_core_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.ce_i(ce_i), .pins_i(pins), .serial_out_o(serial_out_o),
		.serial_out_oe_o(serial_out_oe_o), .busy_o(busy_o), .prog_enabled_o(prog_enabled_o));
	eewr_host eewr_host_inst (.clk_sys_i(clk_sys_i), .pins_o(pins));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// len is the expected busy length in cycles less the first one, zero when nothing may start
	task automatic op(input logic [31:0] bits, input int n, input int len);
		int cnt;
		cnt = 0;
		eewr_host_inst.frame(bits, n);
		repeat (2) @(negedge clk_sys_i);
		check("busy", busy_o, 32'(len != 0));
		while (busy_o === 1'b1 && cnt < 2000) begin
			cnt++;
			if (cnt == 10) eewr_host_inst.select(1'b1);
			if (cnt == 12) check("status", {serial_out_oe_o, serial_out_o}, 32'h2);
			@(negedge clk_sys_i);
		end
		check("length", 32'(cnt), 32'(len));
		if (len != 0) begin
			check("ready", {serial_out_oe_o, serial_out_o}, 32'h3);
			@(negedge clk_sys_i);
			check("ready held", {serial_out_oe_o, serial_out_o}, 32'h3);
			eewr_host_inst.select(1'b0);
			repeat (2) @(negedge clk_sys_i);
		end
		check("released", serial_out_oe_o, 32'h0);
		$display("frame of %0d bits done", n);
	endtask
	// clock enable low mid-cycle must stretch the busy time by exactly the frozen cycles
	task automatic frozen_write();
		int cnt;
		cnt = 0;
		eewr_host_inst.frame(WR, 25);
		repeat (2) @(negedge clk_sys_i);
		while (busy_o === 1'b1 && cnt < 2000) begin
			cnt++;
			if (cnt == 3) ce_i = 1'b0;
			if (cnt == 8) ce_i = 1'b1;
			@(negedge clk_sys_i);
		end
		check("frozen length", 32'(cnt), 32'(2 * PC + 5));
		check("frozen word", eewr_core_inst.mem[6'h2a], 32'ha5c3);
		check("released", serial_out_oe_o, 32'h0);
		$display("frozen write done");
	endtask
	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			results();
		end
	end
	initial begin
		repeat (20) @(negedge clk_sys_i);
		rst_i = 1'b0;
		@(negedge clk_sys_i);
		check("enabled", prog_enabled_o, 32'h0);
		op(WR, 25, 0);
		op(WA, 25, 0);
		op(EN, 11, 0);
		check("enabled", prog_enabled_o, 32'h1);
		op(WR >> 1, 24, 0);
		op(WR, 25, 2 * PC);
		check("word", eewr_core_inst.mem[6'h2a], 32'ha5c3);
		frozen_write();
		op(WA, 25, 2 * PC * 64);
		for (int i = 0; i < 64; i++) begin
			check("array word", eewr_core_inst.mem[i], 32'h5a3c);
		end
		op(DIS, 9, 0);
		check("enabled", prog_enabled_o, 32'h0);
		op(WR, 25, 0);
		check("kept word", eewr_core_inst.mem[6'h2a], 32'h5a3c);
		results();
	end
endmodule
